// [include/srx_pkg.sv]
// Purpose: Shared constants and types of the serial receive buffer
// Assumes: Byte-wide character stream from a separate character receiver
// Notes:   Counts are in bytes or frames, not in clock cycles
package srx_pkg;
	localparam int          DATA_W        = 8;
	localparam int          BUF_BYTES     = 2048;
	localparam int          PTR_W         = 12;
	localparam int          FIFO_DEPTH    = 4;
	localparam logic [3:0]  FRAME_LIM_MAX = 4'hA;
	localparam logic [3:0]  FRAME_LIM_MIN = 4'h1;
	localparam logic [11:0] RST_PTR       = 12'h000;
	localparam logic [11:0] RST_COUNT     = 12'h000;

	typedef enum logic [1:0] {
		LM_TWO_NODE    = 2'h0,
		LM_MP_MASTER   = 2'h1,
		LM_HALF_DUPLEX = 2'h2
	} srx_line_mode_e;

	typedef enum logic [1:0] {
		RD_NONE   = 2'h0,
		RD_A_HIGH = 2'h1,
		RD_A_LOW  = 2'h2
	} srx_rx_default_e;

	typedef enum logic [1:0] {
		ST_RUN  = 2'h0,
		ST_DROP = 2'h1
	} srx_state_e;
endpackage

// [include/srx_fifo_if.sv]
// Purpose: Carrier for the small input FIFO of the receive buffer
// Assumes: One clock domain
// Notes:   Valid/ready on both the filling and the draining side
`timescale 1ns/1ps
`default_nettype none
interface srx_fifo_if #(parameter int W = 9);
	logic         wr_valid;
	logic [W-1:0] wr_data;
	logic         wr_ready;
	logic         rd_valid;
	logic [W-1:0] rd_data;
	logic         rd_ready;

	modport fifo (
		input  wr_valid, wr_data, rd_ready,
		output wr_ready, rd_valid, rd_data
	);
	modport user (
		output wr_valid, wr_data, rd_ready,
		input  wr_ready, rd_valid, rd_data
	);
endinterface
`default_nettype wire

// [core/srx_fifo.sv]
// Purpose: Small synchronous FIFO in front of the frame buffer
// Assumes: Depth is a power of two
// Notes:   Full and empty are exact; ready drops when full
`timescale 1ns/1ps
`default_nettype none
module srx_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = 4
) (
	input  wire logic  clk_i,
	input  wire logic  rst_n_i,
	srx_fifo_if.fifo   f
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wp_ff;
	logic [AW:0]  rp_ff;
	logic [AW:0]  nxt_wp;
	logic [AW:0]  nxt_rp;
	logic         full;
	logic         empty;
	logic         push;
	logic         pop;

	always_comb begin
		empty  = (wp_ff == rp_ff);
		full   = (wp_ff[AW-1:0] == rp_ff[AW-1:0]) && (wp_ff[AW] != rp_ff[AW]);
		push   = f.wr_valid && !full;
		pop    = f.rd_ready && !empty;
		nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
		nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
	end

	assign f.wr_ready = !full;
	assign f.rd_valid = !empty;
	assign f.rd_data  = mem[rp_ff[AW-1:0]];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_ff <= '0;
			rp_ff <= '0;
		end else begin
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp_ff[AW-1:0]] <= f.wr_data;
		end
	end
endmodule
`default_nettype wire

// [core/srx_rx_buffer.sv]
// Purpose: Receive frame buffer and line mode control of a serial port
// Assumes: Characters arrive as bytes with a frame end marker on the last
// Notes:   Frames are committed whole, save one whose first byte is taken on a clear at run start; the clear also cuts off a frame being read
`timescale 1ns/1ps
`default_nettype none
module srx_rx_buffer (
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	input  wire logic [7:0]  rx_data_i,
	input  wire logic        rx_valid_i,
	input  wire logic        rx_last_i,
	output logic             rx_ready_o,
	input  wire logic        rx_break_i,
	input  wire logic        run_i,
	input  wire logic        clear_on_start_i,
	input  wire logic        prevent_overwrite_i,
	input  wire logic        whole_buffer_i,
	input  wire logic [3:0]  frame_limit_i,
	input  wire logic [1:0]  line_mode_i,
	input  wire logic        rs485_slave_i,
	input  wire logic [1:0]  rx_default_i,
	input  wire logic        tx_req_i,
	output logic             tx_oe_o,
	output logic [7:0]       rd_data_o,
	output logic             rd_last_o,
	output logic             rd_valid_o,
	input  wire logic        rd_ready_i,
	output logic [11:0]      frame_count_o,
	output logic [11:0]      used_bytes_o,
	output logic             frame_lost_o,
	output logic             break_o,
	output logic             cfg_err_o,
	output logic             slave_mode_o
);
	localparam int W = srx_pkg::DATA_W + 1;

	function automatic logic [3:0] clamp_limit(input logic [3:0] v);
		if (v < srx_pkg::FRAME_LIM_MIN) begin
			return srx_pkg::FRAME_LIM_MIN;
		end
		if (v > srx_pkg::FRAME_LIM_MAX) begin
			return srx_pkg::FRAME_LIM_MAX;
		end
		return v;
	endfunction

	logic                 rst_s1_ff;
	logic                 rst_n_ff;
	logic [W-1:0]         mem [srx_pkg::BUF_BYTES];
	srx_pkg::srx_state_e  state_ff, nxt_state;
	logic [11:0]          wr_ptr_ff, nxt_wr_ptr;
	logic [11:0]          commit_ff, nxt_commit;
	logic [11:0]          rd_ptr_ff, nxt_rd_ptr;
	logic [11:0]          count_ff, nxt_count;
	logic                 skip_ff, nxt_skip;
	logic                 mid_ff, nxt_mid;
	logic                 out_valid_ff, nxt_out_valid;
	logic [W-1:0]         out_ff, nxt_out;
	logic                 run_q_ff;
	logic                 lost_ff, nxt_lost;
	logic                 oe_ff, nxt_oe;
	logic                 brk_ff, nxt_brk;
	logic                 mem_we;
	logic [W-1:0]         head;
	logic [W-1:0]         cur;
	logic [11:0]          used;
	logic                 first_byte;
	logic                 at_limit;
	logic                 buf_full;
	logic                 take;
	logic                 load_out;
	logic                 shared_line;
	logic                 slave_eff;

	srx_fifo_if #(.W(W)) fq ();

	srx_fifo #(.W(W), .DEPTH(srx_pkg::FIFO_DEPTH)) u_fifo (
		.clk_i   (sys_clk_i),
		.rst_n_i (rst_n_ff),
		.f       (fq.fifo)
	);

	// No byte is taken, or offered as taken, while held in reset
	assign fq.wr_valid = rx_valid_i && rst_n_ff;
	assign fq.wr_data  = {rx_last_i, rx_data_i};
	assign rx_ready_o  = fq.wr_ready && rst_n_ff;
	assign head        = fq.rd_data;
	assign cur         = mem[rd_ptr_ff[10:0]];

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_s1_ff <= 1'b0;
			rst_n_ff  <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n_ff  <= rst_s1_ff;
		end
	end

	always_comb begin
		// Byte parked in the output register still counts as stored
		used        = 12'(wr_ptr_ff - rd_ptr_ff + {11'h000, out_valid_ff});
		first_byte  = (wr_ptr_ff == commit_ff);
		at_limit    = !whole_buffer_i
			&& (count_ff >= {8'h00, clamp_limit(frame_limit_i)});
		buf_full    = (used == 12'(srx_pkg::BUF_BYTES));
		slave_eff   = (line_mode_i == srx_pkg::LM_HALF_DUPLEX) && rs485_slave_i;
		shared_line = (line_mode_i == srx_pkg::LM_MP_MASTER)
			|| (line_mode_i == srx_pkg::LM_HALF_DUPLEX);
	end

	always_comb begin
		nxt_state     = state_ff;
		nxt_wr_ptr    = wr_ptr_ff;
		nxt_commit    = commit_ff;
		nxt_rd_ptr    = rd_ptr_ff;
		nxt_count     = count_ff;
		nxt_skip      = skip_ff;
		nxt_mid       = mid_ff;
		nxt_out_valid = out_valid_ff;
		nxt_out       = out_ff;
		nxt_lost      = 1'b0;
		mem_we        = 1'b0;
		take          = 1'b0;
		if (rd_valid_o && rd_ready_i) begin
			nxt_out_valid = 1'b0;
			nxt_mid       = !out_ff[W-1];
			if (out_ff[W-1]) begin
				nxt_count = nxt_count - 12'h001;
			end
		end
		unique case (state_ff)
			srx_pkg::ST_RUN: begin
				if (fq.rd_valid && skip_ff) begin
					take     = 1'b1;
					nxt_skip = !head[W-1];
				end else if (fq.rd_valid) begin
					if ((first_byte && at_limit) || buf_full) begin
						if (prevent_overwrite_i
							|| count_ff == srx_pkg::RST_COUNT) begin
							take       = 1'b1;
							nxt_lost   = 1'b1;
							nxt_skip   = !head[W-1];
							nxt_wr_ptr = commit_ff;
						end else if (!mid_ff && !(rd_valid_o && rd_ready_i)) begin
							nxt_lost = 1'b1;
							if (out_valid_ff && out_ff[W-1]) begin
								nxt_out_valid = 1'b0;
								nxt_count     = count_ff - 12'h001;
							end else begin
								nxt_out_valid = 1'b0;
								nxt_state     = srx_pkg::ST_DROP;
							end
						end
					end else begin
						take       = 1'b1;
						mem_we     = 1'b1;
						nxt_wr_ptr = wr_ptr_ff + 12'h001;
						if (head[W-1]) begin
							nxt_commit = wr_ptr_ff + 12'h001;
							nxt_count  = nxt_count + 12'h001;
						end
					end
				end
				load_out = (!out_valid_ff || (rd_valid_o && rd_ready_i))
					&& (rd_ptr_ff != commit_ff) && (nxt_state == srx_pkg::ST_RUN);
				if (load_out) begin
					nxt_out_valid = 1'b1;
					nxt_out       = cur;
					nxt_rd_ptr    = rd_ptr_ff + 12'h001;
				end
			end
			srx_pkg::ST_DROP: begin
				load_out   = 1'b0;
				nxt_rd_ptr = rd_ptr_ff + 12'h001;
				if (cur[W-1]) begin
					nxt_count = count_ff - 12'h001;
					nxt_state = srx_pkg::ST_RUN;
				end
			end
			default: begin
				load_out  = 1'b0;
				nxt_state = srx_pkg::ST_RUN;
			end
		endcase
		if (clear_on_start_i && run_i && !run_q_ff) begin
			nxt_state     = srx_pkg::ST_RUN;
			nxt_wr_ptr    = srx_pkg::RST_PTR;
			nxt_commit    = srx_pkg::RST_PTR;
			nxt_rd_ptr    = srx_pkg::RST_PTR;
			nxt_count     = srx_pkg::RST_COUNT;
			nxt_out_valid = 1'b0;
			nxt_mid       = 1'b0;
			nxt_skip      = !first_byte;
		end
	end

	assign fq.rd_ready = take;

	always_comb begin
		// break only with A-high default on a two-node link
		nxt_brk = rx_break_i && (rx_default_i == srx_pkg::RD_A_HIGH)
			&& (line_mode_i == srx_pkg::LM_TWO_NODE);
		// drive shared line only when asked and not receiving
		// two-node link keeps its driver on
		if (shared_line) begin
			nxt_oe = tx_req_i && first_byte && !skip_ff;
		end else begin
			nxt_oe = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			state_ff     <= srx_pkg::ST_RUN;
			wr_ptr_ff    <= srx_pkg::RST_PTR;
			commit_ff    <= srx_pkg::RST_PTR;
			rd_ptr_ff    <= srx_pkg::RST_PTR;
			count_ff     <= srx_pkg::RST_COUNT;
			skip_ff      <= 1'b0;
			mid_ff       <= 1'b0;
			out_valid_ff <= 1'b0;
			out_ff       <= '0;
			run_q_ff     <= 1'b0;
			lost_ff      <= 1'b0;
			oe_ff        <= 1'b0;
			brk_ff       <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			wr_ptr_ff    <= nxt_wr_ptr;
			commit_ff    <= nxt_commit;
			rd_ptr_ff    <= nxt_rd_ptr;
			count_ff     <= nxt_count;
			skip_ff      <= nxt_skip;
			mid_ff       <= nxt_mid;
			out_valid_ff <= nxt_out_valid;
			out_ff       <= nxt_out;
			run_q_ff     <= run_i;
			lost_ff      <= nxt_lost;
			oe_ff        <= nxt_oe;
			brk_ff       <= nxt_brk;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (mem_we) begin
			mem[wr_ptr_ff[10:0]] <= head;
		end
	end

	assign rd_valid_o    = out_valid_ff;
	assign rd_data_o     = out_ff[W-2:0];
	assign rd_last_o     = out_ff[W-1];
	assign frame_count_o = count_ff;
	assign used_bytes_o  = used;
	assign frame_lost_o  = lost_ff;
	assign break_o       = brk_ff;
	assign tx_oe_o       = oe_ff;
	// A-high default illegal on shared lines
	assign cfg_err_o     = shared_line && (rx_default_i == srx_pkg::RD_A_HIGH);
	assign slave_mode_o  = slave_eff;
endmodule
`default_nettype wire

// [tb/srx_rx_buffer_asserts.sv]
// Purpose: Port-level checks of the receive buffer
// Assumes: Sees the top module ports only
// Notes:   Quiet until the two-flop reset release is over
`timescale 1ns/1ps
`default_nettype none
module srx_rx_buffer_asserts (
	input  wire logic        sys_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        rx_break_i,
	input  wire logic        run_i,
	input  wire logic        clear_on_start_i,
	input  wire logic [1:0]  line_mode_i,
	input  wire logic        rs485_slave_i,
	input  wire logic [1:0]  rx_default_i,
	input  wire logic        tx_req_i,
	input  wire logic        tx_oe_o,
	input  wire logic [11:0] frame_count_o,
	input  wire logic        break_o,
	input  wire logic        cfg_err_o,
	input  wire logic        slave_mode_o
);
	logic [1:0] up_ff;
	logic [1:0] nxt_up;
	always_comb nxt_up = (up_ff == 2'h3) ? up_ff : up_ff + 2'h1;
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			up_ff <= 2'h0;
		else
			up_ff <= nxt_up;
	end
	default clocking dcb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i || up_ff != 2'h3);
	sequence run_entry;
		!run_i ##1 (run_i && clear_on_start_i);
	endsequence
	chk_clear_start:
	assert property (run_entry |-> ##[1:4] frame_count_o == 12'h000)
		else $error("store not emptied on run entry");
	chk_break_follow:
	assert property (rx_default_i == 2'h1 && line_mode_i == 2'h0 |=>
		break_o == $past(rx_break_i)) else $error("break not passed on");
	chk_break_gate:
	assert property (line_mode_i != 2'h0 |=> !break_o)
		else $error("break on shared line");
	chk_break_idle:
	assert property (rx_default_i == 2'h2 |=> !break_o)
		else $error("break with idle default");
	chk_cfg_flag:
	assert property (line_mode_i != 2'h3 |-> cfg_err_o ==
		(rx_default_i == 2'h1 && line_mode_i != 2'h0))
		else $error("config error flag wrong");
	chk_slave_role:
	assert property (slave_mode_o == (rs485_slave_i && line_mode_i == 2'h2))
		else $error("slave role wrong");
	chk_shared_oe:
	assert property ((line_mode_i == 2'h1 || line_mode_i == 2'h2) &&
		!tx_req_i |=> !tx_oe_o) else $error("driver on without request");
	chk_two_node_oe:
	assert property (line_mode_i == 2'h0 |=> tx_oe_o)
		else $error("two-node driver off");
endmodule
bind srx_rx_buffer srx_rx_buffer_asserts u_chk (.sys_clk_i, .resetn_i,
	.rx_break_i, .run_i, .clear_on_start_i, .line_mode_i, .rs485_slave_i,
	.rx_default_i, .tx_req_i, .tx_oe_o, .frame_count_o, .break_o,
	.cfg_err_o, .slave_mode_o);
`default_nettype wire

// [tb/srx_peer.sv]
// Purpose: Remote serial node sending frames to the receiver
// Assumes: One byte per handshake, last flag on the final byte
// Notes:   Idle data changes every cycle so stale bytes never match
`timescale 1ns/1ps
`default_nettype none
module srx_peer (
	input  wire logic       clk_i,
	input  wire logic       rdy_i,
	input  wire logic       oe_i,
	input  wire logic       shared_i,
	output logic      [7:0] data_o,
	output logic            valid_o,
	output logic            last_o
);
	// Node address, value arbitrary
	localparam logic [7:0] OWN_ADDR = 8'h5A;
	initial begin
		data_o = 8'h00;
		valid_o = 1'b0;
		last_o = 1'b0;
	end
	// Released driver shows no stale value
	always @(negedge clk_i)
		if (!valid_o)
			data_o <= ~data_o;
	task automatic send(input logic [7:0] fr[$]);
		logic ok;
		// Wait while the device drives a shared line
		while (shared_i && oe_i)
			@(posedge clk_i);
		foreach (fr[j]) begin
			valid_o <= 1'b1;
			data_o <= fr[j];
			last_o <= (j == fr.size() - 1);
			do begin
				@(negedge clk_i);
				ok = rdy_i;
				@(posedge clk_i);
			end while (!ok);
		end
		valid_o <= 1'b0;
		last_o <= 1'b0;
	endtask
	// Answer only a broadcast carrying this node's address
	task automatic reply(input logic [7:0] addr, input logic [7:0] fr[$],
		output bit sent);
		sent = (addr == OWN_ADDR);
		if (sent)
			send(fr);
	endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Purpose: Self-checking bench of the receive buffer
// Assumes: Peer feeds frames; the bench reads them back
// Notes:   Frame store model kept in queues
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        sys_clk_i;
	logic        resetn_i;
	wire  [7:0]  rx_data_i;
	wire         rx_valid_i;
	wire         rx_last_i;
	logic        rx_ready_o;
	logic        rx_break_i;
	logic        run_i;
	logic        clear_on_start_i;
	logic        prevent_overwrite_i;
	logic        whole_buffer_i;
	logic [3:0]  frame_limit_i;
	logic [1:0]  line_mode_i;
	logic        rs485_slave_i;
	logic [1:0]  rx_default_i;
	logic        tx_req_i;
	logic        tx_oe_o;
	logic [7:0]  rd_data_o;
	logic        rd_last_o;
	logic        rd_valid_o;
	logic        rd_ready_i;
	logic [11:0] frame_count_o;
	logic [11:0] used_bytes_o;
	logic        frame_lost_o;
	logic        break_o;
	int          err_total;
	int          samples_checked;
	int          seed;
	int          ml[$];
	logic [7:0]  mb[$];
	logic [3:0]  lv[4];
	int          i;
	int          lost_seen = 0;
	int          lost_exp;
	logic [7:0]  adr;
	srx_rx_buffer u_dut (.sys_clk_i, .resetn_i, .rx_data_i, .rx_valid_i,
		.rx_last_i, .rx_ready_o, .rx_break_i, .run_i, .clear_on_start_i,
		.prevent_overwrite_i, .whole_buffer_i, .frame_limit_i, .line_mode_i,
		.rs485_slave_i, .rx_default_i, .tx_req_i, .tx_oe_o, .rd_data_o,
		.rd_last_o, .rd_valid_o, .rd_ready_i, .frame_count_o,
		.used_bytes_o, .frame_lost_o, .break_o, .cfg_err_o(),
		.slave_mode_o());
	srx_peer u_peer (.clk_i(sys_clk_i), .rdy_i(rx_ready_o), .oe_i(tx_oe_o),
		.shared_i(line_mode_i != 2'h0), .data_o(rx_data_i),
		.valid_o(rx_valid_i), .last_o(rx_last_i));
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	always @(negedge sys_clk_i)
		if (frame_lost_o === 1'b1)
			lost_seen++;
	task automatic chk(input string nm, input logic [11:0] s, e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic give_verdict();
		if (err_total == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic cnt(input int e);
		@(negedge sys_clk_i);
		chk("count", frame_count_o, 12'(e));
		chk("used", used_bytes_o, 12'(mb.size()));
		@(posedge sys_clk_i);
	endtask
	task automatic frame(input int n);
		int lim;
		bit sent;
		logic [7:0] fr[$];
		repeat (n) fr.push_back(8'($random(seed)));
		u_peer.reply(adr, fr, sent);
		lim = whole_buffer_i ? 4096 : frame_limit_i == 4'h0 ? 1 :
			frame_limit_i > 4'hA ? 10 : int'(frame_limit_i);
		// Make room by dropping the oldest
		while (sent && !prevent_overwrite_i && ml.size() > 0 &&
			(ml.size() >= lim || mb.size() + n > 2048)) begin
			repeat (ml.pop_front()) void'(mb.pop_front());
			lost_exp++;
		end
		if (sent && ml.size() < lim && mb.size() + n <= 2048) begin
			ml.push_back(n);
			mb = {mb, fr};
		end else if (sent) begin
			lost_exp++;
		end
		repeat (4) @(posedge sys_clk_i);
	endtask
	task automatic drain();
		int k;
		if (ml.size() > 0)
			rd_ready_i <= 1'b1;
		for (k = 0; k < 4000 && ml.size() > 0; k++) begin
			@(negedge sys_clk_i);
			if (rd_valid_o === 1'b1) begin
				chk("rd_data", rd_data_o, mb.pop_front());
				chk("rd_last", rd_last_o, ml[0] == 1);
				ml[0]--;
				if (ml[0] == 0)
					void'(ml.pop_front());
			end
			@(posedge sys_clk_i);
		end
		rd_ready_i <= 1'b0;
		chk("left", 12'(ml.size()), 12'h000);
		ml = {};
		mb = {};
		cnt(0);
	endtask
	initial begin
		seed = 87451;
		lv = '{4'h2, 4'h1, 4'h0, 4'hC};
		resetn_i = 1'b0;
		rx_break_i = 1'b0;
		run_i = 1'b0;
		clear_on_start_i = 1'b0;
		prevent_overwrite_i = 1'b1;
		whole_buffer_i = 1'b1;
		frame_limit_i = 4'hA;
		line_mode_i = 2'h0;
		rs485_slave_i = 1'b0;
		rx_default_i = 2'h1;
		tx_req_i = 1'b0;
		rd_ready_i = 1'b0;
		err_total = 0;
		samples_checked = 0;
		lost_exp = 0;
		adr = u_peer.OWN_ADDR;
		repeat (10) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		run_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		repeat (9) frame(256);
		cnt(8);
		drain();
		adr = ~u_peer.OWN_ADDR;
		frame(5);
		cnt(0);
		adr = u_peer.OWN_ADDR;
		whole_buffer_i <= 1'b0;
		for (i = 0; i < 4; i++) begin
			prevent_overwrite_i <= ~i[0];
			frame_limit_i <= lv[i];
			@(posedge sys_clk_i);
			repeat (11) frame(1 + ($random(seed) & 7));
			repeat (12) @(posedge sys_clk_i);
			cnt(ml.size());
			drain();
		end
		whole_buffer_i <= 1'b1;
		for (i = 0; i < 2; i++) begin
			clear_on_start_i <= i[0];
			frame(3);
			run_i <= 1'b0;
			repeat (3) @(posedge sys_clk_i);
			run_i <= 1'b1;
			repeat (4) @(posedge sys_clk_i);
			if (i == 1)
				ml = {};
			if (i == 1)
				mb = {};
			cnt(ml.size());
			drain();
		end
		for (i = 0; i < 9; i++) begin
			line_mode_i <= 2'(i / 3);
			rx_default_i <= 2'(i % 3);
			rs485_slave_i <= 1'($random(seed));
			tx_req_i <= 1'($random(seed));
			rx_break_i <= 1'($random(seed));
			repeat (3) @(posedge sys_clk_i);
			@(negedge sys_clk_i);
			chk("break", break_o, i == 1 && rx_break_i);
			chk("tx_oe", tx_oe_o, i < 3 || tx_req_i);
			@(posedge sys_clk_i);
		end
		chk("frame_lost", 12'(lost_seen), 12'(lost_exp));
		give_verdict();
	end
	initial begin
		#(8 * 40000);
		err_total++;
		give_verdict();
	end
endmodule
`default_nettype wire
